// *** rtl/mfos_map.svh ***
/*
  Register indexes, reset values, bit positions and function codes of the
  output-select bank. Assumes inclusion by bare name from the bank's files.
*/
`ifndef MFOS_MAP_SVH
`define MFOS_MAP_SVH

// Word indexes; byte address is four times the index
`define MFOS_IDX_SEL1 12'h311
`define MFOS_IDX_SEL2 12'h312
`define MFOS_IDX_SEL3 12'h313
`define MFOS_IDX_SEL4 12'h314
`define MFOS_IDX_SEL5 12'h315
`define MFOS_IDX_SEL6 12'h316
`define MFOS_IDX_SEL7 12'h317
`define MFOS_IDX_SEL8 12'h318
`define MFOS_IDX_SEL9 12'h319
`define MFOS_IDX_POL 12'h340
`define MFOS_IDX_STATUS 12'h341
`define MFOS_IDX_THR 12'h342
`define MFOS_IDX_CARD 12'h343

`define MFOS_RST_SEL1 16'h000B
`define MFOS_RST_SEL2 16'h0001
`define MFOS_RST_SEL_ZERO 16'h0000
`define MFOS_RST_POL 16'h0000
`define MFOS_RST_THR 16'h0000
`define MFOS_RST_CARD 2'h0

// Status and polarity bit of each output
`define MFOS_BIT_OUT1 4'h0
`define MFOS_BIT_OUT2 4'h1
`define MFOS_BIT_OUT3 4'h3
`define MFOS_BIT_OUT4 4'h4
`define MFOS_BIT_OUT5 4'h5
`define MFOS_BIT_OUT6 4'h6
`define MFOS_BIT_OUT7 4'h7
`define MFOS_BIT_OUT8 4'h8
`define MFOS_BIT_OUT9 4'h9
`define MFOS_STATUS_USED 16'h03FB

`define MFOS_NUM_OUT 9
`define MFOS_COND_W 64
`define MFOS_FC_OVERRIDE 16'h002D
`define MFOS_FC_FREQ_GE 16'h003A
`define MFOS_FC_FREQ_LT 16'h003B

// Card-fitted control bits
`define MFOS_CARD_TRANSISTOR 0
`define MFOS_CARD_RELAY 1

`define MFOS_HSIZE_WORD 3'h2
`define MFOS_ADDR_HI_ZERO 18'h00000

`endif

// *** rtl/mfos_pkg.sv ***
/*
  Types of the output-select bank: bus phase enum and the state structs.
  Assumes mfos_map.svh is on the include path.
*/
package mfos_pkg;
  typedef logic [15:0] mfos_code_t;

  typedef enum logic {
    MFOS_PH_IDLE,
    MFOS_PH_WRITE
  } mfos_phase_t;

  typedef struct packed {
    mfos_phase_t phase;
    logic [11:0] idx;
    logic hit;
    logic [31:0] rdata;
  } mfos_bus_t;

  typedef struct packed {
    logic active;
    logic make;
    logic brk;
  } mfos_cell_t;

  typedef struct packed {
    logic [8:0][15:0] sel;
    logic [15:0] pol;
    logic [15:0] thr;
    logic [1:0] card;
    logic ovr_meta;
    logic ovr_sync;
  } mfos_top_t;
endpackage

// *** rtl/mfos_ahb_slave.sv ***
/*
  AHB-Lite slave front end for the output-select bank: zero wait states,
  always OKAY, registered read data, write strobe in the data phase.
  Assumes single word transfers from one master on hclk.
*/
`include "mfos_map.svh"
module mfos_ahb_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [11:0] rd_idx,
  input wire logic [15:0] rd_value,
  output logic wr_en,
  output logic [11:0] wr_idx,
  output logic [15:0] wr_data
);
  import mfos_pkg::*;

  mfos_bus_t s_q;
  mfos_bus_t s_d;
  logic take;
  logic hit;

  assign take = hsel && htrans[1] && hready;
  assign hit = (haddr[31:14] == `MFOS_ADDR_HI_ZERO) && (hsize == `MFOS_HSIZE_WORD);
  assign rd_idx = haddr[13:2];

  always_comb begin
    s_d = s_q;
    if (hready) begin
      s_d.phase = (take && hwrite) ? MFOS_PH_WRITE : MFOS_PH_IDLE;
      s_d.idx = haddr[13:2];
      s_d.hit = hit;
    end
    // Unmapped or refused reads return zero
    if (take && !hwrite) begin
      s_d.rdata = hit ? {16'h0000, rd_value} : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{phase: MFOS_PH_IDLE, idx: 12'h000, hit: 1'b0, rdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign wr_en = (s_q.phase == MFOS_PH_WRITE) && s_q.hit;
  assign wr_idx = s_q.idx;
  assign wr_data = hwdata[15:0];
endmodule

// *** rtl/mfos_output_cell.sv ***
/*
  One multi-function output: picks the condition named by its function code,
  applies polarity and card gating, and registers status and pin levels.
  Assumes all inputs are already on hclk.
*/
`include "mfos_map.svh"
module mfos_output_cell (
  input wire logic hclk,
  input wire logic hresetn,
  input wire mfos_pkg::mfos_code_t func_code,
  input wire logic [63:0] drive_condition,
  input wire logic [15:0] output_frequency,
  input wire logic [15:0] freq_threshold,
  input wire logic override_level,
  input wire logic polarity,
  input wire logic fitted,
  output logic out_active,
  output logic pin_make,
  output logic pin_break
);
  import mfos_pkg::*;

  mfos_cell_t c_q;
  mfos_cell_t c_d;
  logic cond;

  always_comb begin
    c_d = c_q;
    cond = 1'b0;
    if (func_code == `MFOS_FC_OVERRIDE) begin
      cond = override_level; // RULE_15
    end else if (func_code == `MFOS_FC_FREQ_GE) begin
      cond = output_frequency >= freq_threshold; // RULE_14
    end else if (func_code == `MFOS_FC_FREQ_LT) begin
      cond = output_frequency < freq_threshold; // RULE_14
    end else if (func_code < 16'(`MFOS_COND_W)) begin
      cond = drive_condition[func_code[5:0]];
    end
    c_d.active = cond ^ polarity; // RULE_16
    c_d.make = c_d.active && fitted; // RULE_12
    c_d.brk = !(c_d.active && fitted);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c_q <= '{active: 1'b0, make: 1'b0, brk: 1'b1};
    end else begin
      c_q <= c_d;
    end
  end

  assign out_active = c_q.active;
  assign pin_make = c_q.make;
  assign pin_break = c_q.brk;
endmodule

// *** rtl/mfos_top.sv ***
/*
  Multi-function output select bank: nine function selectors, the shared
  polarity word, the output status word and the output pins, behind AHB-Lite.
  Assumes drive conditions and output frequency come from hclk logic; the
  emergency-override input is asynchronous and is synchronised here.
*/
// Local design decision: the AHB-Lite interface to the registers.
// Summary of operation
// RULE_01 - Output one selector at index 0311, reset 11, status and polarity bit 0.
// RULE_02 - Output two selector at index 0312, reset 1, status and polarity bit 1.
// RULE_03 - Output three selector at index 0313, reset 0, bit 3; bit 2 unused.
// RULE_04 - Output four selector at index 0314, reset 0, status and polarity bit 4.
// RULE_05 - Output five selector at index 0315, reset 0, status and polarity bit 5.
// RULE_06 - Output six selector at index 0316, reset 0, status and polarity bit 6.
// RULE_07 - Output seven selector at index 0317, reset 0, status and polarity bit 7.
// RULE_08 - Output eight selector at index 0318, reset 0, status and polarity bit 8.
// RULE_09 - Output nine selector at index 0319, resets to zero.
// RULE_10 - Output nine reports on status bit 9, polarity from bit 9.
// RULE_11 - Every selector is a 16-bit unsigned read/write function code.
// RULE_12 - Outputs five to nine act only when their expansion card is fitted.
// RULE_13 - Each output's make/break sense comes from its own polarity bit.
// RULE_14 - Code 58 asserts at frequency >= threshold; code 59 below threshold.
// RULE_15 - Code 45 follows the emergency-override input, never latching.
// RULE_16 - Output and status bit equal selected condition XOR polarity bit.
`include "mfos_map.svh"
module mfos_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [63:0] drive_condition,
  input wire logic [15:0] output_frequency,
  input wire logic emergency_override,
  output logic relay_one_make_contact,
  output logic relay_one_break_contact,
  output logic relay_two_make_contact,
  output logic relay_two_break_contact,
  output logic onboard_transistor_out_a,
  output logic onboard_transistor_out_b,
  output logic card_transistor_out_a,
  output logic card_transistor_out_b,
  output logic card_relay_out_a,
  output logic card_relay_out_b,
  output logic card_relay_out_c,
  output logic card_relay_out_d,
  output logic card_relay_out_e
);
  import mfos_pkg::*;

  // Status and polarity bit of each output, outputs one to nine
  localparam logic [3:0] BITMAP [`MFOS_NUM_OUT] = '{
    `MFOS_BIT_OUT1, // RULE_01
    `MFOS_BIT_OUT2, // RULE_02
    `MFOS_BIT_OUT3, // RULE_03
    `MFOS_BIT_OUT4, // RULE_04
    `MFOS_BIT_OUT5, // RULE_05
    `MFOS_BIT_OUT6, // RULE_06
    `MFOS_BIT_OUT7, // RULE_07
    `MFOS_BIT_OUT8, // RULE_08
    `MFOS_BIT_OUT9 // RULE_10
  };

  localparam mfos_top_t TOP_RST = '{
    sel: {
      `MFOS_RST_SEL_ZERO, // RULE_09
      `MFOS_RST_SEL_ZERO, // RULE_08
      `MFOS_RST_SEL_ZERO, // RULE_07
      `MFOS_RST_SEL_ZERO, // RULE_06
      `MFOS_RST_SEL_ZERO, // RULE_05
      `MFOS_RST_SEL_ZERO, // RULE_04
      `MFOS_RST_SEL_ZERO, // RULE_03
      `MFOS_RST_SEL2, // RULE_02
      `MFOS_RST_SEL1 // RULE_01
    },
    pol: `MFOS_RST_POL,
    thr: `MFOS_RST_THR,
    card: `MFOS_RST_CARD,
    ovr_meta: 1'b0,
    ovr_sync: 1'b0
  };

  mfos_top_t s_q;
  mfos_top_t s_d;
  logic [11:0] rd_idx;
  logic [15:0] rd_value;
  logic wr_en;
  logic [11:0] wr_idx;
  logic [15:0] wr_data;
  logic wr_sel_hit;
  logic [3:0] wr_slot;
  logic [15:0] status_word;
  logic [`MFOS_NUM_OUT-1:0] fitted;
  logic [`MFOS_NUM_OUT-1:0] active;
  logic [`MFOS_NUM_OUT-1:0] make;
  logic [`MFOS_NUM_OUT-1:0] brk;

  mfos_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rd_idx(rd_idx),
    .rd_value(rd_value),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data)
  );

  assign wr_sel_hit = (wr_idx >= `MFOS_IDX_SEL1) && (wr_idx <= `MFOS_IDX_SEL9);
  assign wr_slot = 4'(wr_idx - `MFOS_IDX_SEL1);

  // Register writes and the override synchroniser
  always_comb begin
    s_d = s_q;
    s_d.ovr_meta = emergency_override;
    s_d.ovr_sync = s_q.ovr_meta;
    if (wr_en) begin
      if (wr_sel_hit) begin
        s_d.sel[wr_slot] = wr_data; // RULE_11
      end else if (wr_idx == `MFOS_IDX_POL) begin
        s_d.pol = wr_data;
      end else if (wr_idx == `MFOS_IDX_THR) begin
        s_d.thr = wr_data;
      end else if (wr_idx == `MFOS_IDX_CARD) begin
        s_d.card = wr_data[1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= TOP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Read decode; status is read-only, unmapped words read zero
  always_comb begin
    rd_value = 16'h0000;
    if ((rd_idx >= `MFOS_IDX_SEL1) && (rd_idx <= `MFOS_IDX_SEL9)) begin
      rd_value = s_q.sel[4'(rd_idx - `MFOS_IDX_SEL1)]; // RULE_11
    end else if (rd_idx == `MFOS_IDX_POL) begin
      rd_value = s_q.pol;
    end else if (rd_idx == `MFOS_IDX_STATUS) begin
      rd_value = status_word;
    end else if (rd_idx == `MFOS_IDX_THR) begin
      rd_value = s_q.thr;
    end else if (rd_idx == `MFOS_IDX_CARD) begin
      rd_value = {14'h0000, s_q.card};
    end
  end

  // Outputs one to four are on board; five and six sit on either card
  always_comb begin
    fitted = '1;
    fitted[4] = s_q.card[`MFOS_CARD_TRANSISTOR] || s_q.card[`MFOS_CARD_RELAY]; // RULE_12
    fitted[5] = s_q.card[`MFOS_CARD_TRANSISTOR] || s_q.card[`MFOS_CARD_RELAY]; // RULE_12
    fitted[6] = s_q.card[`MFOS_CARD_RELAY]; // RULE_12
    fitted[7] = s_q.card[`MFOS_CARD_RELAY]; // RULE_12
    fitted[8] = s_q.card[`MFOS_CARD_RELAY]; // RULE_12
  end

  for (genvar i = 0; i < `MFOS_NUM_OUT; i++) begin : g_out
    mfos_output_cell u_cell (
      .hclk(hclk),
      .hresetn(hresetn),
      .func_code(s_q.sel[i]),
      .drive_condition(drive_condition),
      .output_frequency(output_frequency),
      .freq_threshold(s_q.thr),
      .override_level(s_q.ovr_sync),
      .polarity(s_q.pol[BITMAP[i]]), // RULE_13
      .fitted(fitted[i]),
      .out_active(active[i]),
      .pin_make(make[i]),
      .pin_break(brk[i])
    );
  end

  // Unused status bits, including bit 2, read zero
  always_comb begin
    status_word = 16'h0000;
    for (int i = 0; i < `MFOS_NUM_OUT; i++) begin
      status_word[BITMAP[i]] = active[i]; // RULE_16
    end
  end

  assign relay_one_make_contact = make[0];
  assign relay_one_break_contact = brk[0];
  assign relay_two_make_contact = make[1];
  assign relay_two_break_contact = brk[1];
  assign onboard_transistor_out_a = make[2];
  assign onboard_transistor_out_b = make[3];
  // Which card carries outputs five and six decides which pin moves
  assign card_transistor_out_a = make[4] && s_q.card[`MFOS_CARD_TRANSISTOR];
  assign card_transistor_out_b = make[5] && s_q.card[`MFOS_CARD_TRANSISTOR];
  assign card_relay_out_a = make[4] && s_q.card[`MFOS_CARD_RELAY];
  assign card_relay_out_b = make[5] && s_q.card[`MFOS_CARD_RELAY];
  assign card_relay_out_c = make[6];
  assign card_relay_out_d = make[7];
  assign card_relay_out_e = make[8];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_sel1_reset;
    $rose(hresetn) |-> (s_q.sel[0] == `MFOS_RST_SEL1) && (status_word == 16'h0000);
  endproperty
  a_sel1_reset: assert property (p_sel1_reset) else $error("output one selector reset wrong"); // RULE_01

  property p_sel2_reset;
    $rose(hresetn) |-> (s_q.sel[1] == `MFOS_RST_SEL2) && (s_q.sel[2] == `MFOS_RST_SEL_ZERO);
  endproperty
  a_sel2_reset: assert property (p_sel2_reset) else $error("output two or three selector reset wrong"); // RULE_02

  property p_status_gap;
    (status_word & ~`MFOS_STATUS_USED) == 16'h0000;
  endproperty
  a_status_gap: assert property (p_status_gap) else $error("unused status bit set"); // RULE_03

  property p_sel_write;
    (wr_en && wr_sel_hit) |=> (s_q.sel[$past(wr_slot)] == $past(wr_data));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selector did not take written code"); // RULE_11

  property p_sel9_write;
    (wr_en && (wr_idx == `MFOS_IDX_SEL9)) |=> (s_q.sel[8] == $past(wr_data));
  endproperty
  a_sel9_write: assert property (p_sel9_write) else $error("output nine selector not written"); // RULE_09

  property p_pol_invert;
    ($changed(s_q.pol[4]) && $stable(s_q.sel[3]) && $stable(drive_condition) &&
      $stable(output_frequency) && $stable(s_q.thr) && $stable(s_q.ovr_sync)) |=> $changed(status_word[4]);
  endproperty
  a_pol_invert: assert property (p_pol_invert) else $error("polarity bit 4 did not invert output four"); // RULE_13

  property p_relay_pin;
    (relay_one_make_contact == status_word[0]) && (relay_one_break_contact != relay_one_make_contact);
  endproperty
  a_relay_pin: assert property (p_relay_pin) else $error("relay one contacts disagree with status"); // RULE_16

  property p_card_off;
    !s_q.card[`MFOS_CARD_RELAY] |=> !card_relay_out_c && !card_relay_out_d && !card_relay_out_e;
  endproperty
  a_card_off: assert property (p_card_off) else $error("card relay moved without card"); // RULE_12

  property p_out9_status;
    $past(s_q.card[1]) |-> (card_relay_out_e == status_word[9]);
  endproperty
  a_out9_status: assert property (p_out9_status) else $error("output nine pin differs from status bit 9"); // RULE_10

  property p_freq_ge;
    ((s_q.sel[2] == `MFOS_FC_FREQ_GE) && (output_frequency >= s_q.thr) && !s_q.pol[3]) |=> status_word[3];
  endproperty
  a_freq_ge: assert property (p_freq_ge) else $error("frequency at or above threshold not shown"); // RULE_14

  property p_freq_lt;
    ((s_q.sel[5] == `MFOS_FC_FREQ_LT) && (output_frequency >= s_q.thr) && !s_q.pol[6]) |=> !status_word[6];
  endproperty
  a_freq_lt: assert property (p_freq_lt) else $error("below-threshold output set at high frequency"); // RULE_14

  property p_override;
    ((s_q.sel[4] == `MFOS_FC_OVERRIDE) && !s_q.pol[5]) |=> (status_word[5] == $past(s_q.ovr_sync));
  endproperty
  a_override: assert property (p_override) else $error("override output does not follow input"); // RULE_15

  property p_ovr_sync;
    s_q.ovr_sync == $past(s_q.ovr_meta);
  endproperty
  a_ovr_sync: assert property (p_ovr_sync) else $error("override synchroniser skipped a stage"); // RULE_15

  property p_pol_write;
    (wr_en && (wr_idx == `MFOS_IDX_POL)) |=> (s_q.pol == $past(wr_data));
  endproperty
  a_pol_write: assert property (p_pol_write) else $error("polarity word not written"); // RULE_13

  property p_status_ro;
    (wr_en && (wr_idx == `MFOS_IDX_STATUS)) |=>
      $stable(s_q.sel) && $stable(s_q.pol) && $stable(s_q.thr) && $stable(s_q.card);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write changed a register");

  property p_relay_two_pin;
    (relay_two_make_contact == status_word[1]) && (relay_two_break_contact != relay_two_make_contact);
  endproperty
  a_relay_two_pin: assert property (p_relay_two_pin) else $error("relay two contacts wrong"); // RULE_02

  property p_onboard_pins;
    (onboard_transistor_out_a == status_word[3]) && (onboard_transistor_out_b == status_word[4]);
  endproperty
  a_onboard_pins: assert property (p_onboard_pins) else $error("on-board pins wrong"); // RULE_04

  property p_card_transistor;
    ($past(s_q.card[`MFOS_CARD_TRANSISTOR]) && s_q.card[`MFOS_CARD_TRANSISTOR]) |->
      (card_transistor_out_a == status_word[5]) && (card_transistor_out_b == status_word[6]);
  endproperty
  a_card_transistor: assert property (p_card_transistor) else $error("transistor card pins wrong"); // RULE_05

  property p_card_relay;
    ($past(s_q.card[`MFOS_CARD_RELAY]) && s_q.card[`MFOS_CARD_RELAY]) |->
      (card_relay_out_a == status_word[5]) && (card_relay_out_b == status_word[6]);
  endproperty
  a_card_relay: assert property (p_card_relay) else $error("relay card pins wrong"); // RULE_06

  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready and OKAY");

  property p_cov_write;
    wr_en && wr_sel_hit;
  endproperty
  c_cov_write: cover property (p_cov_write);

  property p_cov_override;
    (s_q.sel[0] == `MFOS_FC_OVERRIDE) ##1 $rose(status_word[0]);
  endproperty
  c_cov_override: cover property (p_cov_override);

  property p_cov_card;
    s_q.card[1] ##1 $rose(card_relay_out_e);
  endproperty
  c_cov_card: cover property (p_cov_card);

  property p_cov_freq;
    (s_q.sel[2] == `MFOS_FC_FREQ_GE) ##1 status_word[3];
  endproperty
  c_cov_freq: cover property (p_cov_freq);

  property p_cov_status_write;
    wr_en && (wr_idx == `MFOS_IDX_STATUS);
  endproperty
  c_cov_status_write: cover property (p_cov_status_write);
endmodule

// *** tb/mfos_contacts.sv ***
/*
  Far-side load model: relay coils and transistor loads on the bank's pins.
  A contact or load reports closed while its pin is driven high.
  Assumes the pins are hclk-domain levels from mfos_top.
*/
module mfos_contacts (
  input wire logic relay_one_make_contact,
  input wire logic relay_one_break_contact,
  input wire logic relay_two_make_contact,
  input wire logic relay_two_break_contact,
  input wire logic onboard_transistor_out_a,
  input wire logic onboard_transistor_out_b,
  input wire logic card_transistor_out_a,
  input wire logic card_transistor_out_b,
  input wire logic card_relay_out_a,
  input wire logic card_relay_out_b,
  input wire logic card_relay_out_c,
  input wire logic card_relay_out_d,
  input wire logic card_relay_out_e,
  output logic [12:0] closed
);
  timeunit 1ns;
  timeprecision 1ps;
  assign closed = {relay_one_make_contact, relay_one_break_contact, relay_two_make_contact,
                   relay_two_break_contact, onboard_transistor_out_a, onboard_transistor_out_b,
                   card_transistor_out_a, card_transistor_out_b, card_relay_out_a, card_relay_out_b,
                   card_relay_out_c, card_relay_out_d, card_relay_out_e};
endmodule

// *** tb/multi_function_output_select_tb_top.sv ***
/*
  Self-checking bench for mfos_top: register reset values, read/write,
  and pin/status levels against an integer model. Assumes mfos_map.svh on
  the include path and a zero-wait AHB-Lite slave.
*/
`include "mfos_map.svh"
module multi_function_output_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic [63:0] drive_condition = 64'h0;
  logic [15:0] output_frequency = 16'h0000;
  logic emergency_override = 1'b0;
  logic [12:0] closed;
  logic r1m, r1b, r2m, r2b, oa, ob, cta, ctb, cra, crb, crc, crd, cre;
  logic [31:0] rng = 32'h30FA9B57;
  logic [31:0] rd;
  logic [2:0] xsize = 3'h2;
  logic [17:0] xhi = 18'h00000;
  logic [15:0] code_m [9];
  logic [15:0] pol_m, thr_m;
  logic [1:0] card_m;
  int bitpos [9] = '{0, 1, 3, 4, 5, 6, 7, 8, 9};
  int fails = 0;
  int checks_done = 0;

  always #20 hclk = ~hclk;

  mfos_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .drive_condition(drive_condition),
    .output_frequency(output_frequency), .emergency_override(emergency_override),
    .relay_one_make_contact(r1m), .relay_one_break_contact(r1b), .relay_two_make_contact(r2m),
    .relay_two_break_contact(r2b), .onboard_transistor_out_a(oa), .onboard_transistor_out_b(ob),
    .card_transistor_out_a(cta), .card_transistor_out_b(ctb), .card_relay_out_a(cra),
    .card_relay_out_b(crb), .card_relay_out_c(crc), .card_relay_out_d(crd), .card_relay_out_e(cre));

  mfos_contacts load (.relay_one_make_contact(r1m), .relay_one_break_contact(r1b),
    .relay_two_make_contact(r2m), .relay_two_break_contact(r2b), .onboard_transistor_out_a(oa),
    .onboard_transistor_out_b(ob), .card_transistor_out_a(cta), .card_transistor_out_b(ctb),
    .card_relay_out_a(cra), .card_relay_out_b(crb), .card_relay_out_c(crc),
    .card_relay_out_d(crd), .card_relay_out_e(cre), .closed(closed));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One single transfer of size xsize; the address phase is held until hready is seen high
  task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= xsize;
    haddr <= {xhi, idx, 2'b00};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("bus response", 32'h0, {31'h0, hresp});
  endtask

  function automatic logic [15:0] model_status();
    logic [15:0] s;
    logic c;
    s = 16'h0000;
    for (int i = 0; i < 9; i++) begin
      case (code_m[i])
        16'h002D: c = emergency_override;
        16'h003A: c = (output_frequency >= thr_m);
        16'h003B: c = (output_frequency < thr_m);
        default: c = (code_m[i] < 64) ? drive_condition[code_m[i][5:0]] : 1'b0;
      endcase
      s[bitpos[i]] = c ^ pol_m[bitpos[i]];
    end
    return s;
  endfunction

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge hclk);
    fails++;
    summarize();
  end

  initial begin
    logic [15:0] st;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      xfer(1'b0, 12'h311 + 12'(i), 32'h0);
      chk("selector reset", (i == 0) ? 32'hB : (i == 1) ? 32'h1 : 32'h0, rd);
    end
    $display("test reset values done");
    xsize = 3'h0;
    xfer(1'b1, 12'h311, 32'h1234);
    xfer(1'b0, 12'h311, 32'h0);
    chk("byte read refused", 32'h0, rd);
    xsize = 3'h2;
    xhi = 18'h00001;
    xfer(1'b1, 12'h311, 32'h1234);
    xhi = 18'h00000;
    xfer(1'b0, 12'h311, 32'h0);
    chk("refused writes", 32'hB, rd);
    $display("test refused accesses done");
    for (int i = 0; i < 9; i++) begin
      rng = lfsr_next(rng);
      xfer(1'b1, 12'h311 + 12'(i), rng);
      xfer(1'b0, 12'h311 + 12'(i), 32'h0);
      chk("selector readback", {16'h0000, rng[15:0]}, rd);
    end
    xfer(1'b1, 12'h3FF, 32'hFFFFFFFF);
    xfer(1'b0, 12'h3FF, 32'h0);
    chk("unmapped read", 32'h0, rd);
    $display("test readback done");
    for (int n = 0; n < 40; n++) begin
      for (int i = 0; i < 9; i++) begin
        rng = lfsr_next(rng);
        case (rng[9:8])
          2'h0: code_m[i] = 16'h002D + 16'(rng[4] ? 13 : 0) + 16'(rng[5]);
          2'h1: code_m[i] = rng[31:16];
          default: code_m[i] = 16'(rng[5:0]);
        endcase
        xfer(1'b1, 12'h311 + 12'(i), {16'h0000, code_m[i]});
      end
      rng = lfsr_next(rng);
      pol_m = rng[15:0];
      thr_m = rng[31:16];
      card_m = 2'(n);
      xfer(1'b1, 12'h340, {16'h0000, pol_m});
      xfer(1'b1, 12'h342, {16'h0000, thr_m});
      xfer(1'b1, 12'h343, {30'h0, card_m});
      rng = lfsr_next(rng);
      drive_condition <= {rng, lfsr_next(rng)};
      output_frequency <= rng[3] ? thr_m : rng[31:16];
      emergency_override <= rng[7];
      repeat (6) @(posedge hclk);
      st = model_status();
      chk("pins", {19'h0, st[0], ~st[0], st[1], ~st[1], st[3], st[4], st[5] & card_m[0], st[6] & card_m[0],
        st[5] & card_m[1], st[6] & card_m[1], st[7] & card_m[1], st[8] & card_m[1],
        st[9] & card_m[1]}, {19'h0, closed});
      xfer(1'b1, 12'h341, 32'hFFFFFFFF);
      xfer(1'b0, 12'h341, 32'h0);
      chk("status word", {16'h0000, st}, rd);
      xfer(1'b0, 12'h340, 32'h0);
      chk("polarity word", {16'h0000, pol_m}, rd);
      xfer(1'b0, 12'h342, 32'h0);
      chk("threshold word", {16'h0000, thr_m}, rd);
      xfer(1'b0, 12'h343, 32'h0);
      chk("card word", {30'h0, card_m}, rd);
    end
    $display("test output functions done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, 12'h311, 32'h0);
    chk("selector after reset", 32'hB, rd);
    xfer(1'b0, 12'h340, 32'h0);
    chk("polarity after reset", 32'h0, rd);
    $display("test mid-run reset done");
    summarize();
  end
endmodule
